// File: verilog/sspc_pkg.sv
// Shared constants, types and register map of the sleep-state power control block.
package sspc_pkg;

    // Wishbone register byte offsets.
    localparam logic [7:0] SSPC_OFS_CTRL = 8'h00;
    localparam logic [7:0] SSPC_OFS_STATE = 8'h04;
    localparam logic [7:0] SSPC_OFS_STATUS = 8'h08;
    localparam logic [7:0] SSPC_OFS_MASK = 8'h0C;
    localparam logic [7:0] SSPC_OFS_ROUTE = 8'h10;
    localparam logic [7:0] SSPC_OFS_USB_OC = 8'h14;

    // Control register field positions.
    localparam int SSPC_CTL_REQ_LO = 0;
    localparam int SSPC_CTL_GO = 3;
    localparam int SSPC_CTL_RI_EN = 4;
    localparam int SSPC_CTL_WAKE = 5;

    // Status and mask bit positions.
    localparam int SSPC_EV_THERM = 0;
    localparam int SSPC_EV_BTN_SLEEP = 1;
    localparam int SSPC_EV_WAKE = 2;
    localparam int SSPC_EV_OVERRIDE = 3;
    localparam int SSPC_EV_OC = 4;
    localparam int SSPC_EV_W = 5;

    // Reset values.
    localparam logic [31:0] SSPC_CTRL_RST = 32'h0000_0000;
    localparam logic [SSPC_EV_W-1:0] SSPC_MASK_RST = 5'h00;
    localparam logic [5:0] SSPC_ROUTE_RST = 6'h00;

    // Timing: ref clock 20 MHz; rtc tick 32768 Hz derived by divider.
    localparam int SSPC_CLK_HZ = 20000000;
    localparam int SSPC_RTC_HZ = 32768;
    localparam int SSPC_RTC_DIV = SSPC_CLK_HZ / SSPC_RTC_HZ;
    localparam int SSPC_OVR_S = 4;
    localparam int SSPC_OVR_TICKS = SSPC_OVR_S * SSPC_RTC_HZ + 1;
    localparam int SSPC_CORE_POWER_GOOD_LOW_RTC = 3;
    localparam int SSPC_DEB_TICKS = 4;

    // Sleep levels.
    typedef enum logic [2:0] {
        SSPC_S0,
        SSPC_S1,
        SSPC_S3,
        SSPC_S4,
        SSPC_S5
    } sspc_sleep_e;

    // Sleep control output group, all active low.
    typedef struct packed {
        logic sleep_level1_ctl_n;
        logic sleep_level3_ctl_n;
        logic sleep_level5_ctl_n;
    } sspc_slp_s;

    // Decoded sleep controls from one state.
    function automatic sspc_slp_s sspc_decode(input sspc_sleep_e st);
        sspc_slp_s o;
        o.sleep_level1_ctl_n = (st == SSPC_S0);
        o.sleep_level3_ctl_n = (st == SSPC_S0) || (st == SSPC_S1);
        o.sleep_level5_ctl_n = !((st == SSPC_S4) || (st == SSPC_S5));
        return o;
    endfunction

endpackage

// File: verilog/sspc_sync_deb.sv
// Two-flop synchroniser with a tick-paced debounce filter.
`timescale 1ns/1ps
module sspc_sync_deb
    import sspc_pkg::*;
#(
    parameter int TICKS = 4
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Sampling pace and raw level.
    input wire logic tick_in,
    input wire logic raw_in,
    // Synchronised level and filtered level.
    output logic sync_out,
    output logic level_out
);
    logic s1_r;
    logic s2_r;
    logic lvl_r;
    logic lvl_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // Filter changes only after the input holds steady for TICKS ticks.
    always_comb begin
        lvl_nxt = lvl_r;
        cnt_nxt = cnt_r;
        if (s2_r == lvl_r) begin
            cnt_nxt = 4'h0;
        end else if (tick_in) begin
            if (cnt_r == 4'(TICKS - 1)) begin
                lvl_nxt = s2_r;
                cnt_nxt = 4'h0;
            end else begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    // Inputs idle high (pulled up), so reset to the inactive level.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            lvl_r <= 1'b1;
            cnt_r <= 4'h0;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            lvl_r <= lvl_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign sync_out = s2_r;
    assign level_out = lvl_r;
endmodule

// File: verilog/sspc_wb_regs.sv
// Wishbone classic slave read mux and write strobe decode.
`timescale 1ns/1ps
module sspc_wb_regs
    import sspc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Wishbone slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    // Register file view.
    input wire logic [31:0] rd_vec_in [6],
    output logic wr_stb_out,
    output logic rd_status_out
);
    logic ack_r;
    logic ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic req;

    // One-wait answer; unmapped offsets read zero and drop writes.
    always_comb begin
        req = wb_cyc_in && wb_stb_in && !ack_r;
        ack_nxt = req;
        dat_nxt = 32'h0000_0000;
        if (req && !wb_we_in && wb_adr_in[1:0] == 2'h0 && wb_adr_in[7:2] < 6'h06) begin
            dat_nxt = rd_vec_in[wb_adr_in[4:2]];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;
    assign wr_stb_out = req && wb_we_in;
    assign rd_status_out = req && !wb_we_in && wb_adr_in == SSPC_OFS_STATUS;
endmodule

// File: verilog/sspc_top.sv
// Sleep-state power sequencing, wake handling and USB overcurrent routing.
`timescale 1ns/1ps
module sspc_top
    import sspc_pkg::*;
#(
    parameter int OVR_TICKS = SSPC_OVR_TICKS,
    parameter int RTC_DIV = SSPC_RTC_DIV
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Wishbone slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [3:0] wb_sel_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    // Board inputs.
    input wire logic thermal_alarm_n_in,
    input wire logic core_power_good_in,
    input wire logic power_button_n_in,
    input wire logic ring_indicate_n_in,
    input wire logic resume_well_reset_n_in,
    input wire logic network_well_reset_n_in,
    input wire logic [5:0] overcurrent_n_in,
    // Board outputs.
    output logic sleep_level1_ctl_n_out,
    output logic sleep_level3_ctl_n_out,
    output logic sleep_level5_ctl_n_out,
    output logic suspend_warning_n_out,
    output logic bus_reset_out_n_out,
    output logic throttle_out,
    output logic system_mgmt_interrupt_n_out,
    output logic control_interrupt_out,
    output logic irq_out,
    // Per host controller overcurrent status, two ports each.
    output logic [1:0] usb_hc1_oc_out,
    output logic [1:0] usb_hc2_oc_out,
    output logic [1:0] usb_hc3_oc_out
);
    // Synchronised and filtered inputs.
    logic therm_n;
    logic btn_n;
    logic ring_n;
    logic pgood_s;
    logic rsm_rst_n_s;
    logic network_well_reset_n_n_s;
    logic [5:0] oc_n_s;
    logic pg1_r;
    logic pg2_r;
    logic [1:0] rr_r;
    logic [1:0] lr_r;
    logic [5:0] oc1_r;
    logic [5:0] oc2_r;

    // Every asynchronous level passes two flops before use.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pg1_r <= 1'b0;
            pg2_r <= 1'b0;
            rr_r <= 2'b00;
            lr_r <= 2'b00;
            oc1_r <= 6'h3F;
            oc2_r <= 6'h3F;
        end else begin
            pg1_r <= core_power_good_in;
            pg2_r <= pg1_r;
            rr_r <= {rr_r[0], resume_well_reset_n_in};
            lr_r <= {lr_r[0], network_well_reset_n_in};
            oc1_r <= overcurrent_n_in;
            oc2_r <= oc1_r;
        end
    end
    assign pgood_s = pg2_r;
    assign rsm_rst_n_s = rr_r[1];
    assign network_well_reset_n_n_s = lr_r[1];
    assign oc_n_s = oc2_r;

    // Rtc timebase divider; it paces debounce and the override timer.
    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic rtc_tick;
    always_comb begin
        rtc_tick = (div_r == 16'(RTC_DIV - 1));
        div_nxt = rtc_tick ? 16'h0000 : div_r + 16'h0001;
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
        end
    end

    // Debounced thermal, human and modem inputs.
    logic [2:0] raw_vec;
    logic [2:0] deb_vec;
    assign raw_vec = {thermal_alarm_n_in, power_button_n_in, ring_indicate_n_in};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_deb
            sspc_sync_deb #(.TICKS(SSPC_DEB_TICKS)) u_deb (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .tick_in(rtc_tick),
                .raw_in(raw_vec[gi]),
                .sync_out(),
                .level_out(deb_vec[gi])
            );
        end
    endgenerate
    assign {therm_n, btn_n, ring_n} = deb_vec;

    // Resume plane is cleared by rst_in, its own reset or the network well reset, and stays cleared while any of them is asserted.
    logic rsm_clr;
    assign rsm_clr = rst_in || !rsm_rst_n_s || !network_well_reset_n_n_s;

    // Register file and events.
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic ri_en_r;
    logic ri_en_nxt;
    logic only_btn_r;
    logic only_btn_nxt;
    logic [SSPC_EV_W-1:0] stat_r;
    logic [SSPC_EV_W-1:0] stat_nxt;
    logic [SSPC_EV_W-1:0] mask_r;
    logic [SSPC_EV_W-1:0] mask_nxt;
    logic [5:0] route_r;
    logic [5:0] route_nxt;
    logic [5:0] oc_r;
    logic [5:0] oc_nxt;
    logic wr_stb;
    logic rd_status;
    logic [31:0] rd_vec [6];
    sspc_sleep_e st_r;
    sspc_sleep_e st_nxt;
    logic warn_r;
    logic warn_nxt;
    logic [17:0] hold_r;
    logic [17:0] hold_nxt;
    logic btn_d_r;
    logic ovr_fire;
    logic ev_press;
    logic wake;
    logic [SSPC_EV_W-1:0] ev;

    sspc_wb_regs u_regs (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in),
        .wb_ack_out(wb_ack_out),
        .wb_dat_out(wb_dat_out),
        .rd_vec_in(rd_vec),
        .wr_stb_out(wr_stb),
        .rd_status_out(rd_status)
    );

    always_comb begin
        rd_vec[0] = {ctrl_r[31:5], ri_en_r, ctrl_r[3:0]};
        rd_vec[1] = {29'h0, st_r};
        rd_vec[2] = {27'h0, stat_r};
        rd_vec[3] = {27'h0, mask_r};
        rd_vec[4] = {26'h0, route_r};
        rd_vec[5] = {26'h0, oc_r};
    end

    // Button press edge, override timing and wake decision.
    always_comb begin
        ev_press = btn_d_r && !btn_n;
        ovr_fire = !btn_n && (hold_r == 18'(OVR_TICKS - 1)) && rtc_tick;
        hold_nxt = btn_n ? 18'h0 : (rtc_tick && !ovr_fire ? hold_r + 18'h1 : hold_r);
        wake = (st_r != SSPC_S0) && !ovr_fire &&
               (ev_press || (!only_btn_r && ri_en_r && !ring_n));
        ev = '0;
        ev[SSPC_EV_THERM] = !therm_n;
        ev[SSPC_EV_BTN_SLEEP] = ev_press && st_r == SSPC_S0;
        ev[SSPC_EV_WAKE] = wake;
        ev[SSPC_EV_OVERRIDE] = ovr_fire;
        ev[SSPC_EV_OC] = |(~oc_n_s);
    end

    // Registers: writes, read-to-clear status (set wins), state sequencing.
    always_comb begin
        ctrl_nxt = ctrl_r;
        ri_en_nxt = ri_en_r;
        mask_nxt = mask_r;
        route_nxt = route_r;
        only_btn_nxt = only_btn_r;
        st_nxt = st_r;
        warn_nxt = warn_r;
        oc_nxt = oc_r | ~oc_n_s;
        stat_nxt = rd_status ? '0 : stat_r;
        stat_nxt = stat_nxt | ev;
        ctrl_nxt[SSPC_CTL_GO] = 1'b0;
        ctrl_nxt[SSPC_CTL_WAKE] = 1'b0;
        if (wr_stb && wb_sel_in[0]) begin
            unique case (wb_adr_in)
                SSPC_OFS_CTRL: begin
                    ctrl_nxt = wb_dat_in;
                    ri_en_nxt = wb_dat_in[SSPC_CTL_RI_EN];
                end
                SSPC_OFS_MASK: mask_nxt = wb_dat_in[SSPC_EV_W-1:0];
                SSPC_OFS_ROUTE: route_nxt = wb_dat_in[5:0];
                // A new overcurrent in the clearing cycle must not be lost.
                SSPC_OFS_USB_OC: oc_nxt = (oc_r & ~wb_dat_in[5:0]) | ~oc_n_s;
                default: ;
            endcase
        end
        // Suspend warning goes first, then the state moves a cycle later; an override sets both in the same cycle.
        if (ovr_fire) begin
            st_nxt = SSPC_S5;
            warn_nxt = 1'b1;
            only_btn_nxt = 1'b1;
        end else if (wake || (st_r != SSPC_S0 && ctrl_r[SSPC_CTL_WAKE])) begin
            st_nxt = SSPC_S0;
            warn_nxt = 1'b0;
            only_btn_nxt = 1'b0;
        end else if (ctrl_r[SSPC_CTL_GO] && st_r == SSPC_S0) begin
            warn_nxt = 1'b1;
        end else if (warn_r && st_r == SSPC_S0) begin
            unique case (ctrl_r[2:0])
                3'h1: st_nxt = SSPC_S1;
                3'h3: st_nxt = SSPC_S3;
                3'h4: st_nxt = SSPC_S4;
                3'h5: st_nxt = SSPC_S5;
                default: warn_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rsm_clr) begin
            ctrl_r <= SSPC_CTRL_RST;
            ri_en_r <= 1'b0;
            mask_r <= SSPC_MASK_RST;
            route_r <= SSPC_ROUTE_RST;
            stat_r <= '0;
            oc_r <= 6'h00;
            st_r <= SSPC_S0;
            warn_r <= 1'b0;
            only_btn_r <= 1'b0;
            hold_r <= 18'h0;
            btn_d_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            ri_en_r <= ri_en_nxt;
            mask_r <= mask_nxt;
            route_r <= route_nxt;
            stat_r <= stat_nxt;
            oc_r <= oc_nxt;
            st_r <= st_nxt;
            warn_r <= warn_nxt;
            only_btn_r <= only_btn_nxt;
            hold_r <= hold_nxt;
            btn_d_r <= btn_n;
        end
    end

    // Registered outputs; sleep controls decode the one state register.
    sspc_slp_s slp;
    logic [SSPC_EV_W-1:0] pend;
    always_comb begin
        slp = sspc_decode(st_r);
        pend = stat_r & mask_r;
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sleep_level1_ctl_n_out <= 1'b1;
            sleep_level3_ctl_n_out <= 1'b1;
            sleep_level5_ctl_n_out <= 1'b1;
            suspend_warning_n_out <= 1'b1;
            bus_reset_out_n_out <= 1'b0;
            throttle_out <= 1'b0;
            system_mgmt_interrupt_n_out <= 1'b1;
            control_interrupt_out <= 1'b0;
            irq_out <= 1'b0;
            usb_hc1_oc_out <= 2'h0;
            usb_hc2_oc_out <= 2'h0;
            usb_hc3_oc_out <= 2'h0;
        end else begin
            sleep_level1_ctl_n_out <= slp.sleep_level1_ctl_n;
            sleep_level3_ctl_n_out <= slp.sleep_level3_ctl_n;
            sleep_level5_ctl_n_out <= slp.sleep_level5_ctl_n;
            suspend_warning_n_out <= !warn_r;
            bus_reset_out_n_out <= pgood_s;
            throttle_out <= !therm_n;
            system_mgmt_interrupt_n_out <= !(|(pend & ~route_r[SSPC_EV_W-1:0]));
            control_interrupt_out <= |(pend & route_r[SSPC_EV_W-1:0]);
            irq_out <= |pend;
            usb_hc1_oc_out <= oc_r[1:0];
            usb_hc2_oc_out <= oc_r[3:2];
            usb_hc3_oc_out <= oc_r[5:4];
        end
    end

    // Sleep controls never disagree with each other.
    a_slp_nest: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (!sleep_level5_ctl_n_out |-> !sleep_level3_ctl_n_out) and
        (!sleep_level3_ctl_n_out |-> !sleep_level1_ctl_n_out))
        else $error("sleep controls inconsistent");
    a_bus_reset: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !pg2_r |=> !bus_reset_out_n_out)
        else $error("bus reset not asserted");
    a_warn_first: assert property (@(posedge ref_clk_in) disable iff (rsm_clr)
        (st_r == SSPC_S0 && !ovr_fire) ##1 (st_r != SSPC_S0)
        |-> $past(warn_r))
        else $error("entered sleep without warning");
    a_ovr_s5: assert property (@(posedge ref_clk_in) disable iff (rsm_clr)
        ovr_fire |=> st_r == SSPC_S5 ##2 !sleep_level5_ctl_n_out)
        else $error("override did not reach soft-off");
    a_btn_wake: assert property (@(posedge ref_clk_in) disable iff (rsm_clr)
        ev_press && st_r != SSPC_S0 && !ovr_fire |=> st_r == SSPC_S0)
        else $error("button press did not wake");
    a_btn_sleep: assert property (@(posedge ref_clk_in) disable iff (rsm_clr)
        ev_press && st_r == SSPC_S0 && !rd_status |=> stat_r[SSPC_EV_BTN_SLEEP])
        else $error("sleep request not flagged");
    a_therm_thr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !therm_n |=> throttle_out)
        else $error("throttle missing on thermal alarm");
    a_oc_route: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !oc_n_s[2] && !rsm_clr |=> ##1 usb_hc2_oc_out[0])
        else $error("overcurrent not routed");
    a_only_btn: assert property (@(posedge ref_clk_in) disable iff (rsm_clr)
        only_btn_r && !ev_press |-> !wake)
        else $error("non-button wake after override");
endmodule

// File: testbench/sspc_board_model.sv
// Board supply model driving the power-good and well-reset inputs of the block.
`timescale 1ns/1ps
module sspc_board_model #(
    parameter int PG_DLY = 20,
    parameter int LOW_MIN = 12,
    parameter int NET_DLY = 30
) (
    // Clock and supply commands.
    input wire logic ref_clk_in,
    input wire logic resume_on_in,
    input wire logic core_on_in,
    // Supply status toward the block.
    output logic resume_well_reset_n_out,
    output logic network_well_reset_n_out,
    output logic core_power_good_out
);
    int up_cnt = 0;
    int low_cnt = 0;
    int rs_cnt = 0;

    initial begin
        resume_well_reset_n_out = 1'b0;
        network_well_reset_n_out = 1'b0;
        core_power_good_out = 1'b0;
    end

    // Power good waits for stable core power and a long enough low time, so
    // a quick supply bounce never produces a short low pulse.
    always @(posedge ref_clk_in) begin
        up_cnt <= core_on_in ? ((up_cnt < PG_DLY) ? up_cnt + 1 : up_cnt) : 0;
        low_cnt <= core_power_good_out ? 0 : ((low_cnt < LOW_MIN) ? low_cnt + 1 : low_cnt);
        core_power_good_out <= core_on_in && (up_cnt >= PG_DLY) && (low_cnt >= LOW_MIN);
        rs_cnt <= resume_on_in ? ((rs_cnt < NET_DLY) ? rs_cnt + 1 : rs_cnt) : 0;
        resume_well_reset_n_out <= resume_on_in && (rs_cnt >= 2);
        network_well_reset_n_out <= resume_on_in && (rs_cnt >= NET_DLY);
    end
endmodule

// File: testbench/sspc_top_tb.sv
// Self-checking testbench of the sleep-state power control block.
`timescale 1ns/1ps
module sspc_top_tb import sspc_pkg::*; ;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [3:0] sel = 4'h0;
    logic therm_n = 1'b1, btn_n = 1'b1, ring_n = 1'b1, res_on = 1'b0, core_on = 1'b0;
    logic [5:0] oc_n = 6'h3F;
    logic ack, l1, l3, l5, warn_n, brst_n, thr, smi_n, control_interrupt, irq, pg, rsm_n, net_n;
    logic [1:0] hc1, hc2, hc3;
    int miscompares = 0;
    int checked = 0;
    logic [2:0] lvl [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
    logic [2:0] outs [4] = '{3'b011, 3'b001, 3'b000, 3'b000};

    sspc_board_model i_board (.ref_clk_in(ref_clk_in), .resume_on_in(res_on),
        .core_on_in(core_on), .resume_well_reset_n_out(rsm_n),
        .network_well_reset_n_out(net_n), .core_power_good_out(pg));

    sspc_top #(.OVR_TICKS(20), .RTC_DIV(4)) i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
        .wb_sel_in(sel), .wb_ack_out(ack), .wb_dat_out(rdat), .thermal_alarm_n_in(therm_n),
        .core_power_good_in(pg), .power_button_n_in(btn_n), .ring_indicate_n_in(ring_n),
        .resume_well_reset_n_in(rsm_n), .network_well_reset_n_in(net_n),
        .overcurrent_n_in(oc_n), .sleep_level1_ctl_n_out(l1), .sleep_level3_ctl_n_out(l3),
        .sleep_level5_ctl_n_out(l5), .suspend_warning_n_out(warn_n),
        .bus_reset_out_n_out(brst_n), .throttle_out(thr), .system_mgmt_interrupt_n_out(smi_n),
        .control_interrupt_out(control_interrupt), .irq_out(irq), .usb_hc1_oc_out(hc1),
        .usb_hc2_oc_out(hc2), .usb_hc3_oc_out(hc3));

    // Free-running 20 MHz clock.
    initial begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One classic cycle; values read right after an edge are the pre-edge ones.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 40) chk(32'h0, 32'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Held for len cycles: 40 passes the debounce filter, short of the override; 200 reaches the override.
    task automatic btn(input int len);
        btn_n <= 1'b0;
        tick(len);
        btn_n <= 1'b1;
        tick(40);
    endtask

    task automatic slp(input logic [2:0] l, input logic [2:0] o, input logic [31:0] st);
        wb(1'b1, SSPC_OFS_CTRL, 32'h18 | 32'(l));
        tick(2);
        chk(warn_n, 1'b0);
        chk(l1, 1'b1);
        tick(3);
        chk({l1, l3, l5}, o);
        rd_chk(SSPC_OFS_STATE, st);
    endtask

    task automatic results;
        $display("Checks %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run of a little over a thousand cycles.
    initial begin
        tick(20000);
        miscompares++;
        results;
    end

    // Main sequence.
    initial begin
        tick(4);
        rst_in <= 1'b0;
        res_on <= 1'b1;
        core_on <= 1'b1;
        tick(4);
        chk(brst_n, 1'b0);
        for (int i = 0; i < 100 && !(pg === 1'b1 && net_n === 1'b1); i++) tick(1);
        tick(4);
        chk(brst_n, 1'b1);
        rd_chk(SSPC_OFS_CTRL, SSPC_CTRL_RST);
        rd_chk(SSPC_OFS_MASK, 32'(SSPC_MASK_RST));
        rd_chk(SSPC_OFS_ROUTE, 32'(SSPC_ROUTE_RST));
        rd_chk(8'h18, 32'h0);
        // An unsupported target level raises the warning for one cycle only.
        wb(1'b1, SSPC_OFS_CTRL, 32'h1A);
        tick(2);
        chk(warn_n, 1'b0);
        tick(2);
        chk(warn_n, 1'b1);
        rd_chk(SSPC_OFS_STATE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            slp(lvl[i], outs[i], 32'(i + 1));
            wb(1'b1, SSPC_OFS_CTRL, 32'h30);
            tick(4);
            chk({l1, l3, l5}, 3'b111);
        end
        rd_chk(SSPC_OFS_STATUS, 32'h0);
        wb(1'b1, SSPC_OFS_MASK, 32'h3);
        wb(1'b1, SSPC_OFS_ROUTE, 32'h1);
        btn(40);
        chk({irq, smi_n, control_interrupt}, 3'b100);
        rd_chk(SSPC_OFS_STATUS, 32'h2);
        tick(3);
        chk(irq, 1'b0);
        therm_n <= 1'b0;
        tick(40);
        chk({thr, smi_n, control_interrupt}, 3'b111);
        therm_n <= 1'b1;
        tick(40);
        chk(thr, 1'b0);
        rd_chk(SSPC_OFS_STATUS, 32'h1);
        wb(1'b1, SSPC_OFS_MASK, 32'h0);
        btn(40);
        chk(irq, 1'b0);
        rd_chk(SSPC_OFS_STATUS, 32'h2);
        slp(3'h3, 3'b001, 32'h2);
        btn(40);
        rd_chk(SSPC_OFS_STATE, 32'h0);
        rd_chk(SSPC_OFS_STATUS, 32'h4);
        slp(3'h3, 3'b001, 32'h2);
        ring_n <= 1'b0;
        tick(40);
        ring_n <= 1'b1;
        tick(20);
        rd_chk(SSPC_OFS_STATE, 32'h0);
        rd_chk(SSPC_OFS_STATUS, 32'h4);
        btn(200);
        rd_chk(SSPC_OFS_STATE, 32'h4);
        chk({l1, l3, l5}, 3'b000);
        rd_chk(SSPC_OFS_STATUS, 32'hA);
        ring_n <= 1'b0;
        tick(40);
        ring_n <= 1'b1;
        tick(20);
        rd_chk(SSPC_OFS_STATE, 32'h4);
        btn(40);
        rd_chk(SSPC_OFS_STATE, 32'h0);
        rd_chk(SSPC_OFS_STATUS, 32'h4);
        for (int i = 0; i < 6; i++) begin
            oc_n <= ~(6'h01 << i);
            tick(10);
            oc_n <= 6'h3F;
            tick(2);
            chk({hc3, hc2, hc1}, 6'h01 << i);
            rd_chk(SSPC_OFS_USB_OC, 32'h1 << i);
            rd_chk(SSPC_OFS_STATUS, 32'h10);
            wb(1'b1, SSPC_OFS_USB_OC, 32'h3F);
            tick(2);
            chk({hc3, hc2, hc1}, 6'h00);
        end
        core_on <= 1'b0;
        tick(6);
        chk(brst_n, 1'b0);
        core_on <= 1'b1;
        for (int i = 0; i < 100 && pg !== 1'b1; i++) tick(1);
        tick(4);
        chk(brst_n, 1'b1);
        results;
    end
endmodule
